//--- bench/sci_card_info_props.sv
`include "sci_card_info_defs.vh"

module sci_info_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Host command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [2:0]  cmd_func,
  input wire logic [16:0] cmd_addr,
  input wire logic [7:0]  cmd_wdata,
  input wire logic        rsp_valid_q,
  input wire logic        rsp_error_q,
  input wire logic [7:0]  rsp_data_q,
  // Firmware port and mode state
  input wire logic        fw_write,
  input wire logic [16:0] fw_addr,
  input wire logic [7:0]  fw_wdata,
  input wire logic [7:0]  card_cap_q,
  input wire logic        high_speed_en_q,
  input wire logic        master_power_en_q,
  input wire logic        power_sel_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rd0, wr0, set_ehs, set_eps;
  assign rd0 = cmd_valid && !cmd_write && cmd_func == 3'd0;
  assign wr0 = cmd_valid && cmd_write && cmd_func == 3'd0;
  // Mode bits may only rise on a host write that sets them
  assign set_ehs = wr0 && cmd_addr == `SCI_A_BUS_SPEED && cmd_wdata[1];
  assign set_eps = wr0 && cmd_addr == `SCI_A_F1_POWER && cmd_wdata[1];

  a_answer_next: assert property (cmd_valid |=> rsp_valid_q)
    else $error("no answer one cycle after a command");
  a_quiet_idle: assert property (!cmd_valid |=> !rsp_valid_q)
    else $error("answer without a command");
  a_func_refused: assert property (cmd_valid && cmd_func != 3'd0
    |=> rsp_error_q && rsp_data_q == 8'h00)
    else $error("other function not refused");
  a_cap_fixed:
    assert property (card_cap_q == 8'h07)
    else $error("capability byte wrong");
  a_sd_format: assert property (rd0 && cmd_addr == 17'h00001
    |=> rsp_data_q[3:0] == 4'h1)
    else $error("format version wrong");
  a_cis_ptr_mid: assert property (rd0 && cmd_addr == 17'h0000A
    |=> rsp_data_q == 8'h10)
    else $error("common pointer middle byte wrong");
  a_f1_ptr_mid: assert property (rd0 && cmd_addr == 17'h0010A
    |=> rsp_data_q == 8'h20)
    else $error("function pointer middle byte wrong");
  a_ehs_cause: assert property ($rose(high_speed_en_q)
    |-> $past(set_ehs))
    else $error("high speed enabled without host write");
  a_eps_cause: assert property ($rose(power_sel_q) |-> $past(set_eps))
    else $error("power mode changed without host write");
  a_func0_clean: assert property (cmd_valid && cmd_func == 3'd0
    |=> !rsp_error_q)
    else $error("function zero command flagged as error");
  a_data_holds: assert property (!rsp_valid_q && !$past(rst)
    |-> $stable(rsp_data_q))
    else $error("read byte changed without an answer");
endmodule // sci_info_props

bind sci_card_info sci_info_props props_u (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
  .rsp_valid_q(rsp_valid_q), .rsp_error_q(rsp_error_q),
  .rsp_data_q(rsp_data_q), .fw_write(fw_write), .fw_addr(fw_addr),
  .fw_wdata(fw_wdata), .card_cap_q(card_cap_q),
  .high_speed_en_q(high_speed_en_q),
  .master_power_en_q(master_power_en_q), .power_sel_q(power_sel_q)
);

//--- bench/sci_host_model.sv
module sci_host_model (
  // Clock
  input  wire logic        clk,
  // Command request
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [2:0]       cmd_func,
  output logic [16:0]      cmd_addr,
  output logic [7:0]       cmd_wdata,
  // Answer
  input  wire logic        rsp_valid_q,
  input  wire logic        rsp_error_q,
  input  wire logic [7:0]  rsp_data_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_func  = 3'd0;
    cmd_addr  = 17'h00000;
    cmd_wdata = 8'h00;
  end

  task automatic xfer(input logic w, input logic [2:0] f,
                      input logic [16:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic e, s);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_func  = f;
    cmd_addr  = a;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    s = rsp_valid_q;
    e = rsp_error_q;
    q = rsp_data_q;
  endtask

  // Released lines flip so a stale value is never mistaken for a live one
  task automatic idle;
    cmd_valid = 1'b0;
    cmd_write = ~cmd_write;
    cmd_func  = ~cmd_func;
    cmd_addr  = ~cmd_addr;
    cmd_wdata = ~cmd_wdata;
    @(posedge clk);
    #1;
  endtask
endmodule // sci_host_model

//--- bench/tb.sv
`include "sci_card_info_defs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, fw_write, cmd_valid, cmd_write;
  logic        rsp_valid_q, rsp_error_q, power_sel_q;
  logic        high_speed_en_q, master_power_en_q;
  logic [2:0]  cmd_func;
  logic [16:0] cmd_addr, fw_addr;
  logic [7:0]  cmd_wdata, fw_wdata, rsp_data_q, card_cap_q;
  int          n_mismatch = 0;
  int          n_compared = 0;

  sci_card_info dut_u (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid_q(rsp_valid_q), .rsp_error_q(rsp_error_q),
    .rsp_data_q(rsp_data_q), .fw_write(fw_write), .fw_addr(fw_addr),
    .fw_wdata(fw_wdata), .card_cap_q(card_cap_q),
    .high_speed_en_q(high_speed_en_q),
    .master_power_en_q(master_power_en_q), .power_sel_q(power_sel_q));
  sci_host_model host_u (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid_q(rsp_valid_q), .rsp_error_q(rsp_error_q),
    .rsp_data_q(rsp_data_q));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic rw(input logic w, input logic [2:0] f, input logic [16:0] a,
                    input logic [7:0] d, output logic [7:0] q, output logic e);
    logic s;
    host_u.xfer(w, f, a, d, q, e, s);
    host_u.idle();
    `CHK("answer", 1'b1, s)
  endtask

  task automatic rchk(input logic [16:0] a, input logic [7:0] m, x);
    logic [7:0] q;
    logic       e;
    rw(1'b0, 3'd0, a, 8'h00, q, e);
    `CHK($sformatf("read %h", a), x, q & m)
    `CHK("read error flag", 1'b0, e)
  endtask

  task automatic ro(input logic [16:0] a, input logic [7:0] x);
    logic [7:0] q;
    logic       e;
    rw(1'b1, 3'd0, a, ~x, q, e);
    `CHK("old byte", x, q)
    rchk(a, 8'hFF, x);
  endtask

  task automatic fw(input logic [16:0] a, input logic [7:0] d);
    fw_addr  = a;
    fw_wdata = d;
    fw_write = 1'b1;
    @(posedge clk);
    #1;
    fw_write = 1'b0;
    fw_addr  = ~a;
    fw_wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [135:0] f0;
    logic [391:0] f1;
    f0 = 136'h21020C0022050000025A20045A0A0100FF;
    f1 = {192'h21020C00220500010000000000000000000000020080FF00,
          200'h1432C805070AB80B581BF4013200C800C8005E017800C800FF};
    rchk(`SCI_A_REVISION, 8'hFF, 8'h32);
    rchk(`SCI_A_SD_FORMAT, 8'h0F, 8'h01);
    rchk(`SCI_A_SPI_INT_CAP, 8'h40, 8'h40);
    rchk(`SCI_A_CARD_CAP, 8'hDF, 8'h07);
    `CHK("capability", 8'h07, card_cap_q)
    rchk(`SCI_A_CIS_PTR0, 8'hFF, 8'h00);
    rchk(`SCI_A_CIS_PTR1, 8'hFF, 8'h10);
    rchk(`SCI_A_CIS_PTR2, 8'hFF, 8'h00);
    rchk(`SCI_A_POWER_CTL, 8'h01, 8'h01);
    rchk(`SCI_A_BUS_SPEED, 8'h03, 8'h01);
    rchk(`SCI_A_F1_IFACE, 8'h4F, 8'h00);
    rchk(`SCI_A_F1_EXT_IFACE, 8'hFF, 8'h00);
    rchk(`SCI_A_F1_POWER, 8'h03, 8'h01);
    rchk(`SCI_A_F1_PTR0, 8'hFF, 8'h00);
    rchk(`SCI_A_F1_PTR1, 8'hFF, 8'h20);
    rchk(`SCI_A_F1_PTR2, 8'hFF, 8'h00);
    for (int i = 0; i < 17; i++)
      rchk(`SCI_F0_CIS_BASE + 17'(i), 8'hFF, f0[135-8*i -: 8]);
    for (int i = 0; i < 49; i++)
      rchk(`SCI_F1_CIS_BASE + 17'(i), 8'hFF, f1[391-8*i -: 8]);
  endtask

  task automatic t_refusals;
    logic [7:0] q;
    logic       e;
    rw(1'b1, 3'd1, `SCI_A_F1_POWER, 8'h02, q, e);
    `CHK("error flag", 1'b1, e)
    `CHK("error data", 8'h00, q)
    `CHK("power select", 1'b0, power_sel_q)
    ro(`SCI_A_CARD_CAP, 8'h07);
    ro(`SCI_A_CIS_PTR1, 8'h10);
    ro(`SCI_F0_CIS_BASE, 8'h21);
    ro(17'h02022, 8'hF4);
    ro(`SCI_A_F1_PTR1, 8'h20);
    rchk(17'h01050, 8'hFF, 8'h00);
  endtask

  task automatic t_modes;
    logic [7:0] q;
    logic       e, s;
    rw(1'b1, 3'd0, `SCI_A_BUS_SPEED, 8'h02, q, e);
    `CHK("high speed", 1'b1, high_speed_en_q)
    rw(1'b1, 3'd0, `SCI_A_POWER_CTL, 8'h02, q, e);
    `CHK("master power", 1'b1, master_power_en_q)
    rchk(`SCI_A_POWER_CTL, 8'h03, 8'h03);
    // Back to back: the read must already see the new mode bit
    host_u.xfer(1'b1, 3'd0, `SCI_A_F1_POWER, 8'h02, q, e, s);
    host_u.xfer(1'b0, 3'd0, `SCI_A_F1_POWER, 8'h00, q, e, s);
    host_u.idle();
    `CHK("power readback", 8'h03, q & 8'h03)
    `CHK("power select", 1'b1, power_sel_q)
    fw(`SCI_A_BUS_SPEED, 8'h00);
    `CHK("high speed off", 1'b0, high_speed_en_q)
    rw(1'b1, 3'd0, `SCI_A_BUS_SPEED, 8'h02, q, e);
    `CHK("high speed held", 1'b0, high_speed_en_q)
  endtask

  task automatic t_firmware;
    fw(`SCI_A_REVISION, 8'h45);
    rchk(`SCI_A_REVISION, 8'hFF, 8'h45);
    fw(17'h01009, 8'h32);
    rchk(17'h01009, 8'hFF, 8'h32);
    fw(17'h0100C, 8'h11);
    rchk(17'h0100C, 8'hFF, 8'h11);
    fw(17'h02014, 8'hAA);
    rchk(17'h02014, 8'hFF, 8'hAA);
    fw(17'h02022, 8'h00);
    rchk(17'h02022, 8'hFF, 8'hF4);
    fw(17'h02007, 8'h00);
    rchk(17'h02007, 8'hFF, 8'h00);
    fw(17'h02018, 8'h99);
    rchk(17'h02018, 8'hFF, 8'h99);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    rchk(`SCI_A_REVISION, 8'hFF, 8'h32);
    rchk(17'h01009, 8'hFF, 8'h5A);
    rchk(17'h02007, 8'hFF, 8'h01);
    rchk(17'h02018, 8'hFF, 8'h14);
    `CHK("power after reset", 1'b0, power_sel_q)
  endtask

  task automatic conclude;
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rst      = 1'b1;
    fw_write = 1'b0;
    fw_addr  = 17'h00000;
    fw_wdata = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_defaults;
    t_refusals;
    t_modes;
    t_firmware;
    conclude;
  end

  // Whole run is a few hundred cycles; this bound leaves a wide margin
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude;
  end
endmodule // tb

//--- src/sci_card_info.v
// Overview of operation
// - Revision byte: format 2, version 3
// - SD format version 1 at 0x01
// - Continuous SPI interrupt bit reads one
// - SDC set; direct commands during transfers
// - SMB set; block mode multi-block supported
// - SRW set; read-wait on data line 2
// - SBS clear; no suspend or resume
// - S4MI clear; no inter-block interrupts
// - LSC and 4BLS clear: full speed
// - Common pointer 0x001000, low byte first
// - POWER_CONTROL_CAPABILITY set; power control bits functional
// - BUS_SPEED_CAPABILITY default one; high speed needs EHS
// - Function 1 interface codes all zero
// - F1_POWER_SELECTION set; EPS selects power mode
// - Function 1 pointer 0x002000 at 0x109
// - Function 0 tuple chain order fixed
// - Max speed code 0x5A, firmware changeable
// - Manufacturer tuple: maker then card code
// - Function info 0x01, standard revision 0x00
// - Max block 512, no code storage
// - Operating conditions word 0x00FF8000
// - Enable timeout 0x01F4; end at 0x30
// - Host reaches everything via function 0

`include "sci_card_info_defs.vh"

module sci_card_info (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Direct command register port
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [2:0]  cmd_func,
  input  wire [16:0] cmd_addr,
  input  wire [7:0]  cmd_wdata,
  output reg         rsp_valid_q,
  output reg         rsp_error_q,
  output reg  [7:0]  rsp_data_q,
  // On-card firmware update port
  input  wire        fw_write,
  input  wire [16:0] fw_addr,
  input  wire [7:0]  fw_wdata,
  // Capability and mode state to the card logic
  output reg  [7:0]  card_cap_q,
  output reg         high_speed_en_q,
  output reg         master_power_en_q,
  output reg         power_sel_q
);

  // ----------------------------------------------------------------
  // Firmware-modifiable storage
  // ----------------------------------------------------------------
  reg  [7:0]  revision_q;
  reg         shs_q;
  reg  [7:0]  max_speed_q;
  reg  [15:0] maker_q;
  reg  [15:0] card_code_q;
  reg  [7:0]  f1_info_q;
  reg  [31:0] psn_q;
  reg  [31:0] ocr_q;
  reg  [7:0]  f1_pwr_q [0:`SCI_F1_PWR_N-1];

  wire        f0_cis_hit;
  wire        f1_cis_hit;
  wire [5:0]  f0_ofs;
  wire [5:0]  f1_ofs;
  wire        fw_f1_hit;
  wire [5:0]  fw_f1_ofs;
  wire [5:0]  fw_pwr_idx;
  wire [5:0]  rd_pwr_idx;
  wire        host_wr;
  reg  [7:0]  rd_byte;

  // ----------------------------------------------------------------
  // Named copies of constants
  // ----------------------------------------------------------------
  // A bare literal cannot be sliced, so slices come from these
  localparam [16:0] F0_CIS_BASE = `SCI_F0_CIS_BASE;
  localparam [16:0] F1_CIS_BASE = `SCI_F1_CIS_BASE;
  localparam [23:0] CIS_PTR     = `SCI_CIS_PTR_VAL;
  localparam [23:0] F1_PTR      = `SCI_F1_PTR_VAL;
  localparam [15:0] BLK_SIZE    = `SCI_BLK_SIZE;

  // Chains are short, so only the low six offset bits are decoded
  assign f0_cis_hit = (cmd_addr[16:6] == F0_CIS_BASE[16:6]);
  assign f1_cis_hit = (cmd_addr[16:6] == F1_CIS_BASE[16:6]);
  assign f0_ofs     = cmd_addr[5:0];
  assign f1_ofs     = cmd_addr[5:0];
  assign fw_f1_hit  = (fw_addr[16:6] == F1_CIS_BASE[16:6]);
  assign fw_f1_ofs  = fw_addr[5:0];
  assign fw_pwr_idx = fw_f1_ofs - `SCI_F1_PWR_FIRST;
  assign rd_pwr_idx = f1_ofs - `SCI_F1_PWR_FIRST;
  assign host_wr    = cmd_valid & cmd_write & (cmd_func == 3'h0);

  // ----------------------------------------------------------------
  // Firmware writes
  // ----------------------------------------------------------------
  // Firmware sees the same byte map as the host; bytes outside the
  // modifiable set simply do not exist as storage, so writes drop.
  always @(posedge clk) begin
    if (rst) begin
      revision_q  <= `SCI_REVISION_RST;
      shs_q       <= `SCI_SHS_RST;
      max_speed_q <= `SCI_MAX_SPEED_RST;
      maker_q     <= `SCI_MAKER_RST;
      card_code_q <= `SCI_CARD_RST;
      f1_info_q   <= `SCI_F1_INFO_RST;
      psn_q       <= `SCI_PSN_RST;
      ocr_q       <= `SCI_OCR_RST;
    end else if (fw_write) begin
      if (fw_addr == `SCI_A_REVISION) begin
        revision_q <= fw_wdata;
      end
      if (fw_addr == `SCI_A_BUS_SPEED) begin
        shs_q <= fw_wdata[`SCI_SHS_BIT];
      end
      if (fw_addr == `SCI_F0_CIS_BASE + 17'h00009) begin
        max_speed_q <= fw_wdata;
      end
      if (fw_addr == `SCI_F0_CIS_BASE + 17'h0000C) begin
        maker_q[7:0] <= fw_wdata;
      end
      if (fw_addr == `SCI_F0_CIS_BASE + 17'h0000D) begin
        maker_q[15:8] <= fw_wdata;
      end
      if (fw_addr == `SCI_F0_CIS_BASE + 17'h0000E) begin
        card_code_q[7:0] <= fw_wdata;
      end
      if (fw_addr == `SCI_F0_CIS_BASE + 17'h0000F) begin
        card_code_q[15:8] <= fw_wdata;
      end
      if (fw_f1_hit) begin
        case (fw_f1_ofs)
          6'h07: f1_info_q <= fw_wdata;
          6'h09: psn_q[7:0] <= fw_wdata;
          6'h0A: psn_q[15:8] <= fw_wdata;
          6'h0B: psn_q[23:16] <= fw_wdata;
          6'h0C: psn_q[31:24] <= fw_wdata;
          6'h14: ocr_q[7:0] <= fw_wdata;
          6'h15: ocr_q[15:8] <= fw_wdata;
          6'h16: ocr_q[23:16] <= fw_wdata;
          6'h17: ocr_q[31:24] <= fw_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Current-figure table, one byte per entry
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SCI_F1_PWR_N; gi = gi + 1) begin : g_pwr
      wire [191:0] rst_vec;
      wire         is_timeout;
      assign rst_vec = `SCI_F1_PWR_RST;
      // Timeout bytes sit inside the table span yet never change
      // timeout bytes fixed
      assign is_timeout = (gi == 10) || (gi == 11);
      always @(posedge clk) begin
        if (rst) begin
          f1_pwr_q[gi] <= rst_vec[8*gi+7:8*gi];
        end else if (fw_write && fw_f1_hit && !is_timeout &&
                     fw_f1_ofs >= `SCI_F1_PWR_FIRST &&
                     fw_f1_ofs <= `SCI_F1_PWR_LAST &&
                     fw_pwr_idx == gi) begin
          f1_pwr_q[gi] <= fw_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Host-writable enables
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      high_speed_en_q   <= 1'b0;
      master_power_en_q <= 1'b0;
      power_sel_q       <= 1'b0;
      card_cap_q        <= `SCI_CAP_VAL;
    end else begin
      card_cap_q <= `SCI_CAP_VAL;
      // Commands for other functions never reach these bits
      if (host_wr && cmd_addr == `SCI_A_BUS_SPEED) begin
        high_speed_en_q <= cmd_wdata[`SCI_EHS_BIT] & shs_q;
      end
      if (host_wr && cmd_addr == `SCI_A_POWER_CTL) begin
        master_power_en_q <= cmd_wdata[`SCI_EMPC_BIT];
      end
      if (host_wr && cmd_addr == `SCI_A_F1_POWER) begin
        power_sel_q <= cmd_wdata[`SCI_EPS_BIT];
      end
      // Dropping support also drops the mode, so timing never
      // stays fast after firmware withdraws the capability
      if (!shs_q) begin
        high_speed_en_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always @* begin
    rd_byte = 8'h00;
    case (cmd_addr)
      `SCI_A_REVISION:    rd_byte = revision_q;
      `SCI_A_SD_FORMAT:   rd_byte = `SCI_SD_FORMAT_VAL;
      `SCI_A_SPI_INT_CAP: rd_byte = 8'h01 << `SCI_SPI_INT_BIT;
      `SCI_A_CARD_CAP:    rd_byte = card_cap_q;
      `SCI_A_CIS_PTR0:    rd_byte = CIS_PTR[7:0];
      `SCI_A_CIS_PTR1:    rd_byte = CIS_PTR[15:8];
      `SCI_A_CIS_PTR2:    rd_byte = CIS_PTR[23:16];
      `SCI_A_POWER_CTL: begin
        rd_byte[`SCI_POWER_CONTROL_CAPABILITY_BIT] = 1'b1;
        rd_byte[`SCI_EMPC_BIT] = master_power_en_q;
      end
      `SCI_A_BUS_SPEED: begin
        rd_byte[`SCI_SHS_BIT] = shs_q;
        rd_byte[`SCI_EHS_BIT] = high_speed_en_q;
      end
      `SCI_A_F1_IFACE:     rd_byte = `SCI_F1_IFACE_VAL;
      `SCI_A_F1_EXT_IFACE: rd_byte = `SCI_F1_EXT_VAL;
      `SCI_A_F1_POWER: begin
        rd_byte[`SCI_SPS_BIT] = 1'b1;
        rd_byte[`SCI_EPS_BIT] = power_sel_q;
      end
      `SCI_A_F1_PTR0: rd_byte = F1_PTR[7:0];
      `SCI_A_F1_PTR1: rd_byte = F1_PTR[15:8];
      `SCI_A_F1_PTR2: rd_byte = F1_PTR[23:16];
      default: begin
        if (f0_cis_hit) begin
          case (f0_ofs)
            6'h00: rd_byte = `SCI_T_FUNCID;
            6'h01: rd_byte = `SCI_T_FUNCID_LINK;
            6'h02: rd_byte = `SCI_T_FUNC_CODE;
            6'h03: rd_byte = `SCI_T_SYSINIT;
            6'h04: rd_byte = `SCI_T_FUNCE;
            6'h05: rd_byte = `SCI_T_FUNCE_LINK;
            6'h06: rd_byte = `SCI_T_TYPE_F0;
            6'h07: rd_byte = BLK_SIZE[7:0];
            6'h08: rd_byte = BLK_SIZE[15:8];
            6'h09: rd_byte = max_speed_q;
            6'h0A: rd_byte = `SCI_T_MANFID;
            6'h0B: rd_byte = `SCI_T_MANFID_LINK;
            6'h0C: rd_byte = maker_q[7:0];
            6'h0D: rd_byte = maker_q[15:8];
            6'h0E: rd_byte = card_code_q[7:0];
            6'h0F: rd_byte = card_code_q[15:8];
            `SCI_F0_END_OFS: rd_byte = `SCI_T_END;
            default: rd_byte = 8'h00;
          endcase
        end else if (f1_cis_hit) begin
          case (f1_ofs)
            6'h00: rd_byte = `SCI_T_FUNCID;
            6'h01: rd_byte = `SCI_T_FUNCID_LINK;
            6'h02: rd_byte = `SCI_T_FUNC_CODE;
            6'h03: rd_byte = `SCI_T_SYSINIT;
            6'h04: rd_byte = `SCI_T_FUNCE;
            6'h05: rd_byte = `SCI_T_FUNCE_LINK;
            6'h06: rd_byte = `SCI_T_TYPE_F1;
            6'h07: rd_byte = f1_info_q;
            6'h08: rd_byte = `SCI_F1_STD_REV;
            6'h09: rd_byte = psn_q[7:0];
            6'h0A: rd_byte = psn_q[15:8];
            6'h0B: rd_byte = psn_q[23:16];
            6'h0C: rd_byte = psn_q[31:24];
            6'h0D, 6'h0E, 6'h0F,
            6'h10, 6'h11: rd_byte = 8'h00;
            6'h12: rd_byte = BLK_SIZE[7:0];
            6'h13: rd_byte = BLK_SIZE[15:8];
            6'h14: rd_byte = ocr_q[7:0];
            6'h15: rd_byte = ocr_q[15:8];
            6'h16: rd_byte = ocr_q[23:16];
            6'h17: rd_byte = ocr_q[31:24];
            `SCI_F1_END_OFS: rd_byte = `SCI_T_END;
            default: begin
              if (f1_ofs >= `SCI_F1_PWR_FIRST &&
                  f1_ofs <= `SCI_F1_PWR_LAST) begin
                rd_byte = f1_pwr_q[rd_pwr_idx[4:0]];
              end
            end
          endcase
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  // Reads return the byte as it stood when the command arrived; a
  // write's effect is visible from the next command onward.
  always @(posedge clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_error_q <= cmd_valid & (cmd_func != 3'h0);
      if (cmd_valid) begin
        rsp_data_q <= (cmd_func == 3'h0) ? rd_byte : 8'h00;
      end
    end
  end

endmodule // sci_card_info

//--- src/sci_card_info_defs.vh
`ifndef SCI_CARD_INFO_DEFS_VH
`define SCI_CARD_INFO_DEFS_VH

// ----------------------------------------------------------------
// Address spaces (17-bit direct command address)
// ----------------------------------------------------------------
`define SCI_AW              17
`define SCI_F0_CIS_BASE     17'h01000
`define SCI_F1_CIS_BASE     17'h02000

// ----------------------------------------------------------------
// Common control registers
// ----------------------------------------------------------------
`define SCI_A_REVISION      17'h00000
`define SCI_A_SD_FORMAT     17'h00001
`define SCI_A_SPI_INT_CAP   17'h00007
`define SCI_A_CARD_CAP      17'h00008
`define SCI_A_CIS_PTR0      17'h00009
`define SCI_A_CIS_PTR1      17'h0000A
`define SCI_A_CIS_PTR2      17'h0000B
`define SCI_A_POWER_CTL     17'h00012
`define SCI_A_BUS_SPEED     17'h00013
`define SCI_REVISION_RST    8'h32
`define SCI_SD_FORMAT_VAL   8'h01
`define SCI_SPI_INT_BIT     6
`define SCI_CAP_VAL         8'h07
`define SCI_CIS_PTR_VAL     24'h001000
`define SCI_POWER_CONTROL_CAPABILITY_BIT        0
`define SCI_EMPC_BIT        1
`define SCI_SHS_BIT         0
`define SCI_EHS_BIT         1
`define SCI_SHS_RST         1'b1

// ----------------------------------------------------------------
// Function 1 basic registers
// ----------------------------------------------------------------
`define SCI_A_F1_IFACE      17'h00100
`define SCI_A_F1_EXT_IFACE  17'h00101
`define SCI_A_F1_POWER      17'h00102
`define SCI_A_F1_PTR0       17'h00109
`define SCI_A_F1_PTR1       17'h0010A
`define SCI_A_F1_PTR2       17'h0010B
`define SCI_F1_IFACE_VAL    8'h00
`define SCI_F1_EXT_VAL      8'h00
`define SCI_SPS_BIT         0
`define SCI_EPS_BIT         1
`define SCI_F1_PTR_VAL      24'h002000

// ----------------------------------------------------------------
// Tuple chains (offsets within each chain)
// ----------------------------------------------------------------
`define SCI_T_FUNCID        8'h21
`define SCI_T_FUNCID_LINK   8'h02
`define SCI_T_FUNC_CODE     8'h0C
`define SCI_T_SYSINIT       8'h00
`define SCI_T_FUNCE         8'h22
`define SCI_T_FUNCE_LINK    8'h05
`define SCI_T_MANFID        8'h20
`define SCI_T_MANFID_LINK   8'h04
`define SCI_T_END           8'hFF
`define SCI_T_TYPE_F0       8'h00
`define SCI_T_TYPE_F1       8'h00
`define SCI_BLK_SIZE        16'h0200
`define SCI_MAX_SPEED_RST   8'h5A
`define SCI_MAKER_RST       16'h0A5A
`define SCI_CARD_RST        16'h0001
`define SCI_F1_INFO_RST     8'h01
`define SCI_F1_STD_REV      8'h00
`define SCI_PSN_RST         32'h00000000
`define SCI_OCR_RST         32'h00FF8000
`define SCI_TIMEOUT_VAL     16'h01F4
`define SCI_F1_PWR_FIRST    6'h18
`define SCI_F1_PWR_LAST     6'h2F
`define SCI_F1_PWR_N        24
`define SCI_F1_PWR_RST      192'h00C80078015E00C800C8003201F41B580BB80A0705C83214
`define SCI_F0_END_OFS      6'h10
`define SCI_F1_END_OFS      6'h30

`endif
